// File: hw/sdp_regs.svh
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

// array shape
`define SDP_ADDR_W 17
`define SDP_DATA_W 8
`define SDP_DEPTH 131072
`define SDP_PORTS 2

// reset values and counter step
`define SDP_ADDR_RST 17'h00000
`define SDP_DATA_RST 8'h00
`define SDP_ADDR_STEP 17'h00001

// output latency select encodings
`define SDP_LAT_FLOW 1'b0
`define SDP_LAT_PIPE 1'b1

`endif

// File: hw/sdp_pkg.sv
`include "sdp_regs.svh"

package sdp_pkg;

	// one memory address and one data byte
	typedef logic [`SDP_ADDR_W-1:0] sdp_addr_t;
	typedef logic [`SDP_DATA_W-1:0] sdp_data_t;

	// address counter action chosen at each edge
	typedef enum logic [1:0] {
		SDP_CNT_CLEAR = 2'b00,
		SDP_CNT_LOAD = 2'b01,
		SDP_CNT_HOLD = 2'b10,
		SDP_CNT_ADVANCE = 2'b11
	} sdp_cnt_op_e;

endpackage : sdp_pkg

// File: hw/sdp_mem.sv
`timescale 1ns/1ps
`include "sdp_regs.svh"

module sdp_mem (
	// clock
	input wire logic clk_i,
	// per port access
	input wire logic wr_en_i [`SDP_PORTS],
	input wire sdp_pkg::sdp_addr_t addr_i [`SDP_PORTS],
	input wire sdp_pkg::sdp_data_t wr_data_i [`SDP_PORTS],
	output logic [`SDP_DATA_W-1:0] rd_data_o [`SDP_PORTS]
);
	import sdp_pkg::*;

	// storage cells, no reset
	sdp_data_t mem_q [`SDP_DEPTH];

	////////////////////////////////////////////////////////////////////
	// writes from both ports; on a clash on one cell port 1's byte wins
	always_ff @(posedge clk_i) begin
		for (int p = 0; p < `SDP_PORTS; p++) begin
			if (wr_en_i[p]) begin
				mem_q[addr_i[p]] <= wr_data_i[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// independent read path per port
	for (genvar p = 0; p < `SDP_PORTS; p++) begin : g_rd
		assign rd_data_o[p] = mem_q[addr_i[p]];
	end

endmodule : sdp_mem

// File: hw/sdp_top.sv
`timescale 1ns/1ps
`include "sdp_regs.svh"


module sdp_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// address and data inputs, one entry per port
	input wire sdp_pkg::sdp_addr_t address_i [`SDP_PORTS],
	input wire sdp_pkg::sdp_data_t data_bus_i [`SDP_PORTS],
	// chip selects and direction, one bit per port
	input wire logic [`SDP_PORTS-1:0] chip_select_n_i,
	input wire logic [`SDP_PORTS-1:0] chip_select_hi_i,
	input wire logic [`SDP_PORTS-1:0] read_write_i,
	input wire logic [`SDP_PORTS-1:0] output_enable_n_i,
	// address counter controls
	input wire logic [`SDP_PORTS-1:0] address_load_strobe_n_i,
	input wire logic [`SDP_PORTS-1:0] counter_advance_n_i,
	input wire logic [`SDP_PORTS-1:0] counter_clear_n_i,
	// latency select, high for pipelined
	input wire logic [`SDP_PORTS-1:0] output_latency_select_i,
	// data bus drive side
	output logic [`SDP_DATA_W-1:0] data_bus_o [`SDP_PORTS],
	output logic [`SDP_PORTS-1:0] data_bus_oe_o
);
	import sdp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// signals between the port logic and the array
	logic mem_wr_en [`SDP_PORTS];
	sdp_addr_t mem_addr [`SDP_PORTS];
	sdp_data_t mem_wr_data [`SDP_PORTS];
	logic [`SDP_DATA_W-1:0] mem_rd_data [`SDP_PORTS];

	////////////////////////////////////////////////////////////////////
	// shared storage; a read of a cell that the other port writes at
	// the same edge returns the old byte, and two writes to one cell
	// at one edge leave port 1's byte behind
	sdp_mem u_mem (
		.clk_i(clk_i),
		.wr_en_i(mem_wr_en),
		.addr_i(mem_addr),
		.wr_data_i(mem_wr_data),
		.rd_data_o(mem_rd_data)
	);

	////////////////////////////////////////////////////////////////////
	// one copy of the port logic per port
	for (genvar p = 0; p < `SDP_PORTS; p++) begin : g_port

		// address register and its next value
		sdp_addr_t addr_ff;
		sdp_addr_t nxt_addr;
		sdp_addr_t addr_plus_one;

		// captured access flags and write byte
		logic wr_ff;
		logic rd_ff;
		sdp_data_t wdata_ff;

		// captured latency select
		logic lat_ff;

		// extra stage for pipelined mode
		sdp_data_t pipe_data_ff;
		logic pipe_rd_ff;

		// output stage and its next values
		sdp_data_t out_ff;
		logic drive_ff;
		sdp_data_t nxt_out;
		logic nxt_drive;

		// decoded controls
		sdp_cnt_op_e cnt_op;
		logic sel_low_ok;
		logic sel_high_ok;
		logic selected;
		logic wr_req;
		logic rd_req;
		logic pipe_mode;

		////////////////////////////////////////////////////////////////
		// counter action; clear beats load beats advance
		always_comb begin
			if (!counter_clear_n_i[p]) begin
				cnt_op = SDP_CNT_CLEAR;
			end else if (!address_load_strobe_n_i[p]) begin
				cnt_op = SDP_CNT_LOAD;
			end else if (!counter_advance_n_i[p]) begin
				cnt_op = SDP_CNT_ADVANCE;
			end else begin
				cnt_op = SDP_CNT_HOLD;
			end
		end

		// next held address plus one; natural overflow wraps to zero
		assign addr_plus_one = sdp_addr_t'(addr_ff + `SDP_ADDR_STEP);

		// next address; chip selects play no part here
		always_comb begin
			case (cnt_op)
				SDP_CNT_CLEAR: begin
					nxt_addr = `SDP_ADDR_RST;
				end
				SDP_CNT_LOAD: begin
					nxt_addr = address_i[p];
				end
				SDP_CNT_ADVANCE: begin
					nxt_addr = addr_plus_one;
				end
				SDP_CNT_HOLD: begin
					nxt_addr = addr_ff;
				end
				default: begin
					nxt_addr = addr_ff;
				end
			endcase
		end

		// address register, updated on every edge; counting goes on
		// while deselected, so a burst can be primed before selection
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				addr_ff <= `SDP_ADDR_RST;
			end else begin
				addr_ff <= nxt_addr;
			end
		end

		////////////////////////////////////////////////////////////////
		// each chip select on its own; either one off deselects
		assign sel_low_ok = ~chip_select_n_i[p];
		assign sel_high_ok = chip_select_hi_i[p];

		// both chip selects must be active for any access
		assign selected = sel_low_ok & sel_high_ok;

		// selected write or read request at this edge
		assign wr_req = selected & ~read_write_i[p];
		assign rd_req = selected & read_write_i[p];

		////////////////////////////////////////////////////////////////
		// write request flag; output enable plays no part, so a write
		// lands even while the drivers are masked
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				wr_ff <= 1'b0;
			end else begin
				wr_ff <= wr_req;
			end
		end

		// read request flag; a deselected edge leaves it low, which
		// keeps the bus undriven for that access
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				rd_ff <= 1'b0;
			end else begin
				rd_ff <= rd_req;
			end
		end

		// write byte, taken on every edge and only used with wr_ff
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				wdata_ff <= `SDP_DATA_RST;
			end else begin
				wdata_ff <= data_bus_i[p];
			end
		end

		// latency select, private to this port
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				lat_ff <= `SDP_LAT_FLOW;
			end else begin
				lat_ff <= output_latency_select_i[p];
			end
		end

		////////////////////////////////////////////////////////////////
		// array side of this port
		assign mem_addr[p] = addr_ff;
		assign mem_wr_en[p] = wr_ff;
		assign mem_wr_data[p] = wdata_ff;

		////////////////////////////////////////////////////////////////
		// extra data stage, only read out in pipelined mode; it runs in
		// both modes so that a mode switch finds it filled
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				pipe_data_ff <= `SDP_DATA_RST;
			end else begin
				pipe_data_ff <= sdp_data_t'(mem_rd_data[p]);
			end
		end

		// read flag travelling beside the extra data stage
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				pipe_rd_ff <= 1'b0;
			end else begin
				pipe_rd_ff <= rd_ff;
			end
		end

		////////////////////////////////////////////////////////////////
		// mode taken at the previous edge; a mid-stream switch may
		// repeat or drop one output cycle
		assign pipe_mode = (lat_ff == `SDP_LAT_PIPE);

		// byte for the output register, from the array or the stage;
		// pipelined mode reads one stage later
		always_comb begin
			case (pipe_mode)
				1'b1: begin
					nxt_out = pipe_data_ff;
				end
				default: begin
					nxt_out = sdp_data_t'(mem_rd_data[p]);
				end
			endcase
		end

		// drive request for the output register, same selection so
		// that data and drive always belong to one access
		always_comb begin
			case (pipe_mode)
				1'b1: begin
					nxt_drive = pipe_rd_ff;
				end
				default: begin
					nxt_drive = rd_ff;
				end
			endcase
		end

		////////////////////////////////////////////////////////////////
		// output byte register
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				out_ff <= `SDP_DATA_RST;
			end else begin
				out_ff <= nxt_out;
			end
		end

		// drive register; a deselected or write access clears it
		always_ff @(posedge clk_i or posedge reset_i) begin
			if (reset_i) begin
				drive_ff <= 1'b0;
			end else begin
				drive_ff <= nxt_drive;
			end
		end

		////////////////////////////////////////////////////////////////
		// output enable gates the drivers without a clock; the enable
		// term is not a pure flop on purpose, it must act at once
		assign data_bus_o[p] = out_ff;
		assign data_bus_oe_o[p] = drive_ff & ~output_enable_n_i[p];

	end

endmodule : sdp_top

// File: verification/sdp_top_assertions.sv
`timescale 1ns/1ps
`include "sdp_regs.svh"

module sdp_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// port controls
	input wire logic [`SDP_PORTS-1:0] chip_select_n_i,
	input wire logic [`SDP_PORTS-1:0] chip_select_hi_i,
	input wire logic [`SDP_PORTS-1:0] read_write_i,
	input wire logic [`SDP_PORTS-1:0] output_enable_n_i,
	input wire logic [`SDP_PORTS-1:0] output_latency_select_i,
	// drive side
	input wire logic [`SDP_PORTS-1:0] data_bus_oe_o
);
	logic [1:0] rd, lat, dis, oe;
	// selected read requests and short aliases
	assign rd = ~chip_select_n_i & chip_select_hi_i & read_write_i;
	assign lat = output_latency_select_i;
	assign dis = output_enable_n_i;
	assign oe = data_bus_oe_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	oe_mask0_a: assert property (dis[0] |-> !oe[0])
		else $error("port 0 driven while disabled");
	oe_mask1_a: assert property (dis[1] |-> !oe[1])
		else $error("port 1 driven while disabled");
	flow_read0_a: assert property (rd[0] && !lat[0] ##1 !lat[0] |=> (oe[0] || dis[0]))
		else $error("port 0 flow read not driven");
	pipe_read0_a: assert property (rd[0] && lat[0] ##1 lat[0] [*2] |=> (oe[0] || dis[0]))
		else $error("port 0 pipelined read not driven");
	flow_idle0_a: assert property (!rd[0] && !lat[0] ##1 !lat[0] |=> !oe[0])
		else $error("port 0 flow drives without read");
	pipe_idle0_a: assert property (!rd[0] && lat[0] ##1 lat[0] [*2] |=> !oe[0])
		else $error("port 0 pipelined drives without read");
	flow_read1_a: assert property (rd[1] && !lat[1] ##1 !lat[1] |=> (oe[1] || dis[1]))
		else $error("port 1 flow read not driven");
	pipe_read1_a: assert property (rd[1] && lat[1] ##1 lat[1] [*2] |=> (oe[1] || dis[1]))
		else $error("port 1 pipelined read not driven");
	// main scenarios
	cover property (rd[0] && lat[0] ##3 oe[0]);
	cover property (rd[1] && !lat[1] ##2 oe[1]);
	cover property (rd[1] && lat[1] ##3 oe[1]);
endmodule : sdp_chk

bind sdp_top sdp_chk u_chk (.*);

// File: verification/sdp_bus_master.sv
`timescale 1ns/1ps
`include "sdp_regs.svh"

module sdp_bus_master (
	// clock
	input wire logic clk_i,
	// master side
	input wire logic drive_i,
	input wire sdp_pkg::sdp_data_t data_i,
	// device side
	input wire logic dev_oe_i,
	input wire logic [`SDP_DATA_W-1:0] dev_data_i,
	// resolved bus level
	output sdp_pkg::sdp_data_t bus_o
);
	import sdp_pkg::*;
	sdp_data_t last_ff;
	// released bus never keeps its last level
	always_ff @(posedge clk_i) begin
		last_ff <= bus_o;
	end
	assign bus_o = drive_i ? data_i : dev_oe_i ? dev_data_i : ~last_ff;
endmodule : sdp_bus_master

// File: verification/sdp_top_tb.sv
`timescale 1ns/1ps
`include "sdp_regs.svh"

module sdp_top_tb;
	import sdp_pkg::*;
	logic clk_i = 0, reset_i = 1;
	logic [1:0] csn = 2'h3, cshi = 2'h0, rw = 2'h3, oen = 2'h3, lat = 2'h0;
	logic [1:0] address_load_strobe_n = 2'h3, adv = 2'h3, clr = 2'h3, oe, mdrv, latq;
	sdp_addr_t adr [2];
	sdp_data_t mdat [2], bus [2], dout [2];
	logic [7:0] mem [int];
	logic [8:0] r1 [2], r2 [2], exp [2], w;
	int cnt [2], fail_count = 0, tests_run = 0;
	////////////////////////////////////////////////////////////////
	sdp_top dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(adr),
		.data_bus_i(bus), .chip_select_n_i(csn), .chip_select_hi_i(cshi),
		.read_write_i(rw), .output_enable_n_i(oen),
		.address_load_strobe_n_i(address_load_strobe_n), .counter_advance_n_i(adv),
		.counter_clear_n_i(clr), .output_latency_select_i(lat),
		.data_bus_o(dout), .data_bus_oe_o(oe));
	// masters drive write data onto each bus
	assign mdrv = ~rw & ~csn & cshi;
	for (genvar g = 0; g < 2; g++) begin : g_bus
		sdp_bus_master u_m (.clk_i(clk_i), .drive_i(mdrv[g]),
			.data_i(mdat[g]), .dev_oe_i(oe[g]), .dev_data_i(dout[g]),
			.bus_o(bus[g]));
	end
	////////////////////////////////////////////////////////////////
	// reference: reads first, then writes, port 1 last
	always @(posedge clk_i or posedge reset_i) begin
		for (int p = 0; p < 2; p++) begin
			// output follows the select taken at the edge before
			exp[p] = reset_i ? 9'h000 : latq[p] ? r2[p] : r1[p];
			latq[p] = reset_i ? 1'b0 : lat[p];
			r2[p] = reset_i ? 9'h000 : r1[p];
			cnt[p] = reset_i || !clr[p] ? 0 : !address_load_strobe_n[p] ? adr[p] :
				!adv[p] ? (cnt[p] + 1) % `SDP_DEPTH : cnt[p];
			r1[p] = {~csn[p] & cshi[p] & rw[p] & ~reset_i,
				mem.exists(cnt[p]) ? mem[cnt[p]] : 8'hxx};
		end
		for (int p = 0; p < 2; p++)
			if (!reset_i && !csn[p] && cshi[p] && !rw[p])
				mem[cnt[p]] = bus[p];
	end
	// compare both buses once settled
	always @(negedge clk_i) begin
		for (int p = 0; p < 2 && !reset_i; p++) begin
			w = exp[p] & {~oen[p], {8{~oen[p] & exp[p][8]}}};
			check({oe[p], dout[p] & {8{oe[p]}}}, w);
		end
	end
	////////////////////////////////////////////////////////////////
	task check(input logic [8:0] seen, input logic [8:0] want);
		tests_run++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH port bus expected %h seen %h", want, seen);
		end
	endtask : check
	// random request on one port
	task drive_port(input int p);
		logic a;
		a = $urandom % 4 != 0;
		address_load_strobe_n[p] <= a;
		rw[p] <= a ? 1'($urandom) : 1'b1;
		adr[p] <= $urandom % 3 ? 17'($urandom % 16) : 17'h1fffe;
		csn[p] <= $urandom % 5 == 0;
		cshi[p] <= $urandom % 5 != 0;
		oen[p] <= $urandom % 4 == 0;
		adv[p] <= 1'($urandom);
		clr[p] <= $urandom % 16 != 0;
		mdat[p] <= 8'($urandom);
	endtask : drive_port
	task report_and_stop;
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	// clock
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// reset, then three latency phases of random traffic
	initial begin
		adr = '{17'h00000, 17'h00000};
		mdat = '{8'h00, 8'h00};
		void'($urandom(32'ha36ab479));
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int ph = 0; ph < 3; ph++) begin
			@(posedge clk_i);
			csn <= 2'h3;
			repeat (2) @(posedge clk_i);
			lat <= {ph > 0, ph > 1};
			repeat (800) begin
				@(posedge clk_i);
				drive_port(0);
				drive_port(1);
			end
		end
		@(posedge clk_i);
		report_and_stop();
	end
endmodule : sdp_top_tb
